// ### rtl/oms_pkg.sv
// Purpose: constants for the operand, multiply and special-register execution block
// Assumes: 32-bit data path, one core clock
// Notes:   selector encodings are local to this block
//------------------------------------------------------------
// package
//------------------------------------------------------------
package oms_pkg;
   localparam int DW = 32;
   localparam int HW = 16;
   // immediate form selector
   typedef enum logic [2:0] {
      OMS_IMM_SHIFTED = 3'h0,
      OMS_IMM_REP_LO  = 3'h1,
      OMS_IMM_REP_HI  = 3'h3,
      OMS_IMM_REP_ALL = 3'h2,
      OMS_IMM_OTHER   = 3'h6
   } oms_imm_e;
   localparam logic [7:0] OMS_BYTE_MAX = 8'hff;
   localparam int         OMS_SHAMT_W  = 5;
   // special register selector
   typedef enum logic [3:0] {
      OMS_SR_APP_STATUS_FLAGS   = 4'h0,
      OMS_SR_IAPSR  = 4'h1,
      OMS_SR_EAPSR  = 4'h2,
      OMS_SR_PSR    = 4'h3,
      OMS_SR_EXCEPTION_NUMBER_VIEW   = 4'h5,
      OMS_SR_EXECUTION_STATE_VIEW   = 4'h6,
      OMS_SR_IEPSR  = 4'h7,
      OMS_SR_MSP    = 4'h8,
      OMS_SR_PSP    = 4'h9,
      OMS_SR_PRIM   = 4'h4,
      OMS_SR_BPRI   = 4'ha,
      OMS_SR_BPMAX  = 4'hb,
      OMS_SR_FMASK  = 4'hc,
      OMS_SR_CTRL   = 4'hd
   } oms_sr_e;
   // status word fields
   localparam int OMS_FLAG_LSB = 27;
   localparam int OMS_FLAG_MSB = 31;
   localparam logic [DW-1:0] OMS_FLAG_MASK  = 32'hf800_0000;
   localparam logic [DW-1:0] OMS_EXEC_MASK  = 32'h0700_fc00;
   localparam logic [DW-1:0] OMS_EXC_MASK   = 32'h0000_01ff;
   localparam logic [DW-1:0] OMS_PSR_RST    = 32'h0100_0000;
   localparam int OMS_PRI_W  = 8;
   localparam int OMS_CTRL_W = 2;
endpackage : oms_pkg

// ### rtl/oms_exec.sv
// Purpose: execution logic for flexible immediates, halfword multiplies and special-register writes
// Assumes: decoded fields arrive valid for one cycle from the pipeline
// Notes:   register shift kinds are outside this block; shift amount is applied as logical left
//
// Contract
// (RULE1) an 8-bit value shifted left by any amount within 32 bits is a legal immediate.
// (RULE2) byte-replicated immediates in bytes 0 and 2, bytes 1 and 3, or all four bytes are produced.
// (RULE3) flag-setting logic ops set carry to immediate bit 31 only when a shifted-byte immediate exceeds 255.
// (RULE4) a register second source is taken from the second source register with an optional shift.
// (RULE5) bit 0 of any address loaded into the program counter selects the instruction set and must be 1.
// (RULE6) the first multiply operand is the low halfword for bottom and the high halfword for top.
// (RULE7) the second multiply operand is the high halfword for top and the low halfword for bottom.
// (RULE8) the halfword multiply writes the full signed 32-bit product.
// (RULE9) the word-by-half multiply writes the upper 32 bits of the signed 48-bit product.
// (RULE10) software never names stack pointer or program counter in these multiplies.
// (RULE11) unprivileged special writes reach only the application flags; privileged reach all.
// (RULE12) unprivileged status-word writes leave unallocated and execution-state bits unchanged.
// (RULE13) the raise-only alias updates the threshold only for nonzero source below it or when it is zero.
// (RULE14) a write to the flags loads them straight from the source bits.
// (RULE15) software never uses stack pointer or program counter as the special-write source.
// (RULE16) the selector decodes status views, both stack pointers, three masks with the alias, and control.
// (RULE17) privilege gates every special write and forbidden writes are dropped without fault; unprivileged status-view writes here still load the flags.
`timescale 1ns/100ps
`default_nettype none
module oms_exec
   import oms_pkg::*;
(
   // clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   // flexible second source
   input  wire logic                       op2_is_imm,
   input  wire oms_pkg::oms_imm_e          imm_form,
   input  wire logic [7:0]                 imm_byte,
   input  wire logic [oms_pkg::OMS_SHAMT_W-1:0] imm_shamt,
   input  wire logic                       op2_flag_logic,
   input  wire logic [oms_pkg::DW-1:0]     second_source_reg,
   input  wire logic [oms_pkg::OMS_SHAMT_W-1:0] reg_shamt,
   input  wire logic                       carry_in,
   output logic [oms_pkg::DW-1:0]          flexible_second_source,
   output logic                            carry_out,
   output logic                            carry_upd,
   // multiply
   input  wire logic                       mul_valid,
   input  wire logic                       mul_word_half,
   input  wire logic                       sel_x_top,
   input  wire logic                       sel_y_top,
   input  wire logic [oms_pkg::DW-1:0]     first_source_reg,
   output logic [oms_pkg::DW-1:0]          mul_result,
   output logic                            mul_done,
   // special register write
   input  wire logic                       msr_valid,
   input  wire oms_pkg::oms_sr_e           msr_sel,
   input  wire logic [oms_pkg::DW-1:0]     msr_src,
   input  wire logic                       privileged,
   input  wire logic [oms_pkg::DW-1:0]     branch_target,
   // special register state
   output logic [oms_pkg::DW-1:0]          program_status_word,
   output logic [oms_pkg::DW-1:0]          main_stack_ptr,
   output logic [oms_pkg::DW-1:0]          process_stack_ptr,
   output logic                            global_irq_mask,
   output logic                            global_fault_mask,
   output logic [oms_pkg::OMS_PRI_W-1:0]   priority_mask_threshold,
   output logic [oms_pkg::OMS_CTRL_W-1:0]  control_reg,
   output logic                            target_state_ok
);
   import oms_pkg::*;

   //------------------------------------------------------------
   // flexible second source
   //------------------------------------------------------------
   function automatic logic [DW-1:0] shl(input logic [DW-1:0] v, input logic [OMS_SHAMT_W-1:0] s);
      shl = v << s;
   endfunction : shl

   logic [DW-1:0] shifted_imm;
   // immediate expansion and carry side effect
   always_comb begin
      shifted_imm = shl({24'h0, imm_byte}, imm_shamt);       // RULE1
      flexible_second_source = shl(second_source_reg, reg_shamt); // RULE4
      carry_out = carry_in;
      carry_upd = 1'b0;
      if (op2_is_imm) begin
         case (imm_form)
            OMS_IMM_SHIFTED: begin
               flexible_second_source = shifted_imm;
               if (op2_flag_logic && (shifted_imm > {24'h0, OMS_BYTE_MAX})) begin
                  carry_out = shifted_imm[DW-1];              // RULE3
                  carry_upd = 1'b1;
               end
            end
            OMS_IMM_REP_LO:  flexible_second_source = {8'h0, imm_byte, 8'h0, imm_byte}; // RULE2
            OMS_IMM_REP_HI:  flexible_second_source = {imm_byte, 8'h0, imm_byte, 8'h0}; // RULE2
            OMS_IMM_REP_ALL: flexible_second_source = {4{imm_byte}}; // RULE2
            default:         flexible_second_source = shifted_imm;
         endcase
      end
   end

   // instruction-set bit of a loaded program counter
   assign target_state_ok = branch_target[0];                 // RULE5

   //------------------------------------------------------------
   // multiplies
   //------------------------------------------------------------
   logic signed [HW-1:0]   op_a;
   logic signed [HW-1:0]   op_b;
   logic signed [2*HW-1:0] prod_hh;
   logic signed [47:0]     prod_wh;
   logic [DW-1:0]          next_mul_result;
   logic                   next_mul_done;
   // operand select and product
   always_comb begin
      op_a    = sel_x_top ? first_source_reg[31:16] : first_source_reg[15:0];   // RULE6
      op_b    = sel_y_top ? second_source_reg[31:16] : second_source_reg[15:0]; // RULE7
      prod_hh = op_a * op_b;                                  // RULE8
      prod_wh = $signed(first_source_reg) * op_b;             // RULE9
      next_mul_result = mul_result;
      next_mul_done   = mul_valid;
      if (mul_valid) begin
         next_mul_result = mul_word_half ? prod_wh[47:16] : prod_hh; // RULE9
      end
   end

   // result register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mul_result <= 32'h0;
         mul_done   <= 1'b0;
      end else begin
         mul_result <= next_mul_result;
         mul_done   <= next_mul_done;
      end
   end

   //------------------------------------------------------------
   // special register writes
   //------------------------------------------------------------
   logic [DW-1:0]        next_psw;
   logic [DW-1:0]        next_msp;
   logic [DW-1:0]        next_psp;
   logic                 next_prim;
   logic                 next_fmask;
   logic [OMS_PRI_W-1:0] next_bpri;
   logic [OMS_CTRL_W-1:0] next_ctrl;
   logic [OMS_PRI_W-1:0] src_pri;
   logic                 psw_sel;
   // decode and privilege gating; forbidden writes are simply dropped
   always_comb begin
      next_psw   = program_status_word;
      next_msp   = main_stack_ptr;
      next_psp   = process_stack_ptr;
      next_prim  = global_irq_mask;
      next_fmask = global_fault_mask;
      next_bpri  = priority_mask_threshold;
      next_ctrl  = control_reg;
      src_pri    = msr_src[OMS_PRI_W-1:0];
      psw_sel    = 1'b0;
      if (msr_valid) begin
         case (msr_sel)                                       // RULE16
            OMS_SR_APP_STATUS_FLAGS, OMS_SR_IAPSR, OMS_SR_EAPSR, OMS_SR_PSR,
            OMS_SR_EXCEPTION_NUMBER_VIEW, OMS_SR_EXECUTION_STATE_VIEW, OMS_SR_IEPSR: psw_sel = 1'b1;
            OMS_SR_MSP:   if (privileged) next_msp = msr_src;  // RULE17
            OMS_SR_PSP:   if (privileged) next_psp = msr_src;  // RULE17
            OMS_SR_PRIM:  if (privileged) next_prim = msr_src[0]; // RULE11
            OMS_SR_FMASK: if (privileged) next_fmask = msr_src[0]; // RULE11
            OMS_SR_BPRI:  if (privileged) next_bpri = src_pri;  // RULE17
            OMS_SR_BPMAX: begin
               if (privileged && (src_pri != 8'h0) &&
                   ((priority_mask_threshold == 8'h0) || (src_pri < priority_mask_threshold))) begin
                  next_bpri = src_pri;                        // RULE13
               end
            end
            OMS_SR_CTRL:  if (privileged) next_ctrl = msr_src[OMS_CTRL_W-1:0]; // RULE17
            default: psw_sel = 1'b0;
         endcase
         if (psw_sel) begin
            // flags load straight from the source bits
            next_psw = (program_status_word & ~OMS_FLAG_MASK) | (msr_src & OMS_FLAG_MASK); // RULE14
            if (privileged) begin
               next_psw = (next_psw & ~OMS_EXEC_MASK) | (msr_src & OMS_EXEC_MASK); // RULE11
            end
            // unprivileged: execution and unallocated bits kept
         end                                                  // RULE12
      end
   end

   // special register state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         program_status_word     <= OMS_PSR_RST;
         main_stack_ptr          <= 32'h0;
         process_stack_ptr       <= 32'h0;
         global_irq_mask         <= 1'b0;
         global_fault_mask       <= 1'b0;
         priority_mask_threshold <= 8'h0;
         control_reg             <= 2'h0;
      end else begin
         program_status_word     <= next_psw;
         main_stack_ptr          <= next_msp;
         process_stack_ptr       <= next_psp;
         global_irq_mask         <= next_prim;
         global_fault_mask       <= next_fmask;
         priority_mask_threshold <= next_bpri;
         control_reg             <= next_ctrl;
      end
   end

   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   property p_carry_shift;
      @(posedge core_clk) disable iff (!rst_n)
      (op2_is_imm && imm_form == OMS_IMM_SHIFTED && op2_flag_logic && shifted_imm > 32'hff)
         |-> (carry_upd && carry_out == shifted_imm[31]);
   endproperty
   a_carry_shift: assert property (p_carry_shift) else $error("carry not set from immediate"); // RULE3

   property p_carry_rep;
      @(posedge core_clk) disable iff (!rst_n)
      (op2_is_imm && imm_form != OMS_IMM_SHIFTED) |-> !carry_upd;
   endproperty
   a_carry_rep: assert property (p_carry_rep) else $error("carry changed by replicated immediate"); // RULE3

   property p_rep_all;
      @(posedge core_clk) disable iff (!rst_n)
      (op2_is_imm && imm_form == OMS_IMM_REP_ALL) |-> flexible_second_source == {4{imm_byte}};
   endproperty
   a_rep_all: assert property (p_rep_all) else $error("replicated immediate wrong"); // RULE2

   property p_mul_hh;
      @(posedge core_clk) disable iff (!rst_n)
      (mul_valid && !mul_word_half) |=> mul_done && mul_result ==
         32'($signed($past(sel_x_top) ? $past(first_source_reg[31:16]) : $past(first_source_reg[15:0]))
           * $signed($past(sel_y_top) ? $past(second_source_reg[31:16]) : $past(second_source_reg[15:0])));
   endproperty
   a_mul_hh: assert property (p_mul_hh) else $error("halfword product wrong"); // RULE8

   property p_mul_wh;
      @(posedge core_clk) disable iff (!rst_n)
      (mul_valid && mul_word_half) |=> mul_done && mul_result == $past(prod_wh[47:16]);
   endproperty
   a_mul_wh: assert property (p_mul_wh) else $error("word by half product wrong"); // RULE9

   sequence s_unpriv_write;
      msr_valid && !privileged && msr_sel inside {OMS_SR_MSP, OMS_SR_PSP, OMS_SR_CTRL, OMS_SR_BPRI};
   endsequence
   property p_unpriv_drop;
      @(posedge core_clk) disable iff (!rst_n)
      s_unpriv_write |=> $stable(main_stack_ptr) && $stable(process_stack_ptr)
         && $stable(control_reg) && $stable(priority_mask_threshold);
   endproperty
   a_unpriv_drop: assert property (p_unpriv_drop) else $error("unprivileged write took effect"); // RULE17

   property p_unpriv_psw;
      @(posedge core_clk) disable iff (!rst_n)
      (msr_valid && !privileged && psw_sel) |=>
         ((program_status_word & ~OMS_FLAG_MASK) == ($past(program_status_word) & ~OMS_FLAG_MASK));
   endproperty
   a_unpriv_psw: assert property (p_unpriv_psw) else $error("protected status bits changed"); // RULE12

   property p_flags_load;
      @(posedge core_clk) disable iff (!rst_n)
      (msr_valid && psw_sel) |=>
         program_status_word[OMS_FLAG_MSB:OMS_FLAG_LSB] == $past(msr_src[OMS_FLAG_MSB:OMS_FLAG_LSB]);
   endproperty
   a_flags_load: assert property (p_flags_load) else $error("flags not loaded"); // RULE14

   property p_raise_only;
      @(posedge core_clk) disable iff (!rst_n)
      (msr_valid && msr_sel == OMS_SR_BPMAX && (src_pri == 8'h0 ||
         (priority_mask_threshold != 8'h0 && src_pri >= priority_mask_threshold)))
         |=> $stable(priority_mask_threshold);
   endproperty
   a_raise_only: assert property (p_raise_only) else $error("threshold lowered through alias"); // RULE13
endmodule : oms_exec
`default_nettype wire

// ### tb/oms_pipe_model.sv
// Purpose: pipeline-side model that hands decoded branch targets to the execution block
// Assumes: decoded fields change on the falling edge of core_clk
// Notes:   bad_target makes the model send an even target so a bad state select can be seen
`timescale 1ns/100ps
`default_nettype none
module oms_pipe_model (
   // clock and bench control
   input  wire logic              core_clk,
   input  wire logic              bad_target,
   // decoded target toward the block
   output logic [oms_pkg::DW-1:0] branch_target
);
   import oms_pkg::*;
   logic [DW-2:0] count = '0;
   //------------------------------------------------------------
   // target generation
   //------------------------------------------------------------
   // a fresh target each cycle; bit 0 stays set unless a fault is asked for
   always @(negedge core_clk) begin
      count <= count + 1'b1;
      branch_target <= {count, ~bad_target};
   end
endmodule : oms_pipe_model
`default_nettype wire

// ### tb/oms_exec_tb.sv
// Purpose: self-checking bench for the operand, multiply and special-register block
// Assumes: inputs change on the falling edge; xorshift stimulus seeded with 8
// Notes:   source values stand for ordinary registers only, never stack pointer or program counter
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("wrong value at %0t: %s", $time, msg); end end
module oms_exec_tb;
   import oms_pkg::*;
   logic           core_clk, rst_n, op2_is_imm, op2_flag_logic, carry_in, carry_out, carry_upd, bad_target;
   logic           mul_valid, mul_word_half, sel_x_top, sel_y_top, mul_done, msr_valid, privileged;
   logic           global_irq_mask, global_fault_mask, target_state_ok, m_prim, m_fm;
   logic [7:0]     imm_byte, priority_mask_threshold, m_bp;
   logic [4:0]     imm_shamt, reg_shamt;
   logic [1:0]     control_reg, m_ctrl;
   logic [DW-1:0]  second_source_reg, flexible_second_source, first_source_reg, mul_result, msr_src;
   logic [DW-1:0]  branch_target, program_status_word, main_stack_ptr, process_stack_ptr;
   logic [DW-1:0]  m_psw, m_msp, m_psp, seed, r, ev;
   logic           eu;
   oms_imm_e       imm_form;
   oms_sr_e        msr_sel;
   int             n_errors, cmp_count;
   oms_imm_e       forms [5] = '{OMS_IMM_SHIFTED, OMS_IMM_REP_LO, OMS_IMM_REP_HI, OMS_IMM_REP_ALL, OMS_IMM_OTHER};
   //------------------------------------------------------------
   // clock, instances
   //------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   oms_exec oms_exec_i (.core_clk(core_clk), .rst_n(rst_n), .op2_is_imm(op2_is_imm), .imm_form(imm_form),
      .imm_byte(imm_byte), .imm_shamt(imm_shamt), .op2_flag_logic(op2_flag_logic),
      .second_source_reg(second_source_reg), .reg_shamt(reg_shamt), .carry_in(carry_in),
      .flexible_second_source(flexible_second_source), .carry_out(carry_out), .carry_upd(carry_upd),
      .mul_valid(mul_valid), .mul_word_half(mul_word_half), .sel_x_top(sel_x_top), .sel_y_top(sel_y_top),
      .first_source_reg(first_source_reg), .mul_result(mul_result), .mul_done(mul_done),
      .msr_valid(msr_valid), .msr_sel(msr_sel), .msr_src(msr_src), .privileged(privileged),
      .branch_target(branch_target), .program_status_word(program_status_word),
      .main_stack_ptr(main_stack_ptr), .process_stack_ptr(process_stack_ptr),
      .global_irq_mask(global_irq_mask), .global_fault_mask(global_fault_mask),
      .priority_mask_threshold(priority_mask_threshold), .control_reg(control_reg),
      .target_state_ok(target_state_ok));
   oms_pipe_model oms_pipe_model_i (.core_clk(core_clk), .bad_target(bad_target), .branch_target(branch_target));
   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   // xorshift stream, fixed start
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // expected flexible immediate
   function automatic logic [31:0] imm_exp(oms_imm_e f, logic [7:0] b, logic [4:0] s);
      case (f)
         OMS_IMM_REP_LO:  return {8'h00, b, 8'h00, b};
         OMS_IMM_REP_HI:  return {b, 8'h00, b, 8'h00};
         OMS_IMM_REP_ALL: return {4{b}};
         default:         return {24'h000000, b} << s;
      endcase
   endfunction : imm_exp
   // expected product of either multiply kind
   function automatic logic [31:0] mul_exp(logic wh, logic xt, logic yt, logic [31:0] a, logic [31:0] b);
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [47:0] p;
      x = xt ? a[31:16] : a[15:0];
      y = yt ? b[31:16] : b[15:0];
      p = wh ? $signed(a) * y : x * y;
      return wh ? p[47:16] : p[31:0];
   endfunction : mul_exp
   // one special write, model update and full compare
   task automatic move_to_special_reg(input oms_sr_e sel, input logic [31:0] src, input logic pv);
      @(negedge core_clk);
      msr_valid = 1'b1;
      msr_sel = sel;
      msr_src = src;
      privileged = pv;
      case (sel)
         // every status view loads the flags; only privileged writes reach the execution bits
         OMS_SR_APP_STATUS_FLAGS, OMS_SR_IAPSR, OMS_SR_EAPSR, OMS_SR_PSR, OMS_SR_EXCEPTION_NUMBER_VIEW, OMS_SR_EXECUTION_STATE_VIEW, OMS_SR_IEPSR: begin
            m_psw = (m_psw & ~OMS_FLAG_MASK) | (src & OMS_FLAG_MASK);
            if (pv) m_psw = (m_psw & ~OMS_EXEC_MASK) | (src & OMS_EXEC_MASK);
         end
         OMS_SR_MSP:   if (pv) m_msp = src;
         OMS_SR_PSP:   if (pv) m_psp = src;
         OMS_SR_PRIM:  if (pv) m_prim = src[0];
         OMS_SR_FMASK: if (pv) m_fm = src[0];
         OMS_SR_BPRI:  if (pv) m_bp = src[7:0];
         OMS_SR_BPMAX: if (pv && src[7:0] != 8'h00 && (m_bp == 8'h00 || src[7:0] < m_bp)) m_bp = src[7:0];
         OMS_SR_CTRL:  if (pv) m_ctrl = src[1:0];
         default:      ;
      endcase
      @(negedge core_clk);
      msr_valid = 1'b0;
      `CHK(program_status_word, m_psw, "status word")
      `CHK(main_stack_ptr, m_msp, "main stack pointer")
      `CHK(process_stack_ptr, m_psp, "process stack pointer")
      `CHK(global_irq_mask, m_prim, "irq mask")
      `CHK(global_fault_mask, m_fm, "fault mask")
      `CHK(priority_mask_threshold, m_bp, "threshold")
      `CHK(control_reg, m_ctrl, "control")
      `CHK(target_state_ok, ~bad_target, "state select")
   endtask : move_to_special_reg
   // ends the run with counts and verdict
   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   //------------------------------------------------------------
   // watchdog and main sequence
   //------------------------------------------------------------
   initial begin
      #20000;
      n_errors++;
      final_report();
   end
   initial begin
      seed = 32'h0000_0008;
      {rst_n, op2_is_imm, op2_flag_logic, carry_in, mul_valid, mul_word_half, sel_x_top, sel_y_top} = '0;
      {msr_valid, privileged, bad_target, imm_byte, imm_shamt, reg_shamt} = '0;
      {second_source_reg, first_source_reg, msr_src} = '0;
      imm_form = OMS_IMM_SHIFTED;
      msr_sel = OMS_SR_APP_STATUS_FLAGS;
      {m_prim, m_fm, m_bp, m_ctrl, m_msp, m_psp} = '0;
      m_psw = OMS_PSR_RST;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      `CHK(program_status_word, OMS_PSR_RST, "reset status word")
      `CHK(mul_done, 1'b0, "reset done")
      $display("test reset done");
      // immediates, register operand and carry side effect
      for (int i = 0; i < 40; i++) begin
         @(negedge core_clk);
         r = rnd();
         imm_form = forms[i % 5];
         imm_byte = (i % 8 == 0) ? 8'hff : (i % 8 == 1) ? 8'h01 : (i % 8 == 2) ? 8'h80 : r[7:0];
         imm_shamt = (i % 8 == 0) ? 5'h00 : (i % 8 == 1) ? 5'h08 : (i % 8 == 2) ? 5'h18 : r[20:16];
         {op2_flag_logic, carry_in, reg_shamt} = {r[8], r[9], r[14:10]};
         op2_is_imm = (i % 3 != 2);
         second_source_reg = rnd();
         #1;
         ev = op2_is_imm ? imm_exp(imm_form, imm_byte, imm_shamt) : second_source_reg << reg_shamt;
         eu = op2_is_imm && op2_flag_logic && imm_form == OMS_IMM_SHIFTED && ev > 32'd255;
         `CHK(flexible_second_source, ev, "operand value")
         `CHK(carry_upd, eu, "carry update")
         if (eu) `CHK(carry_out, ev[31], "carry value")
         else `CHK(carry_out, carry_in, "carry kept")
      end
      $display("test operand done");
      // back-to-back multiplies, all selector pairs first, sign corners first
      for (int i = 0; i <= 24; i++) begin
         @(negedge core_clk);
         if (i > 0) begin
            `CHK(mul_done, 1'b1, "multiply done")
            `CHK(mul_result, ev, "multiply result")
         end
         r = rnd();
         mul_valid = (i < 24);
         {mul_word_half, sel_y_top, sel_x_top} = (i < 8) ? i[2:0] : r[2:0];
         first_source_reg = (i < 4) ? 32'h8000_7fff : rnd();
         second_source_reg = (i < 4) ? 32'h7fff_8000 : rnd();
         ev = mul_exp(mul_word_half, sel_x_top, sel_y_top, first_source_reg, second_source_reg);
      end
      @(negedge core_clk);
      `CHK(mul_done, 1'b0, "done is one cycle")
      $display("test multiply done");
      // every selector with and without privilege, then the raise-only alias
      for (int v = 0; v < 28; v++) move_to_special_reg(oms_sr_e'(v % 14), rnd(), v < 14);
      move_to_special_reg(OMS_SR_BPRI, 32'h0000_0000, 1'b1);
      move_to_special_reg(OMS_SR_BPMAX, 32'h0000_0040, 1'b1);
      move_to_special_reg(OMS_SR_BPMAX, 32'h0000_0060, 1'b1);
      move_to_special_reg(OMS_SR_BPMAX, 32'h0000_0040, 1'b1);
      move_to_special_reg(OMS_SR_BPMAX, 32'h0000_0020, 1'b1);
      move_to_special_reg(OMS_SR_BPMAX, 32'h0000_0000, 1'b1);
      move_to_special_reg(OMS_SR_BPMAX, 32'h0000_0010, 1'b0);
      $display("test alias done");
      // random writes, with an even branch target now and then
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         bad_target = (i % 7 == 0);
         move_to_special_reg(oms_sr_e'(r[3:0] % 14), (r[3:0] == 4'hb) ? {24'h0, r[23:16]} : rnd(), r[4]);
      end
      $display("test special write done");
      final_report();
   end
endmodule : oms_exec_tb
`undef CHK
`default_nettype wire
